// file: pkg/rtm_pkg.sv
// Purpose: Shared constants and types of the radio transmit modulation control.
// Assumes: clk_sys is the crystal reference; register bus words are 32 bits.
// Notes:   Byte address of a register is four times its index.

package rtm_pkg;

  // ==========================================================
  // Clock and synthesizer
  localparam int CLK_HZ   = 100_000_000;
  localparam int SDM_BITS = 19;            // Fractional step is crystal / 2**SDM_BITS

  // ==========================================================
  // Register indices
  localparam logic [6:0] IDX_CTRL     = 7'h01;
  localparam logic [6:0] IDX_BR_MSB   = 7'h03;
  localparam logic [6:0] IDX_BR_LSB   = 7'h04;
  localparam logic [6:0] IDX_FDEV_MSB = 7'h05;
  localparam logic [6:0] IDX_FDEV_LSB = 7'h06;
  localparam logic [6:0] IDX_LEVEL    = 7'h11;
  localparam logic [6:0] IDX_RAMP     = 7'h12;
  localparam logic [6:0] IDX_OCP      = 7'h13;
  localparam logic [6:0] IDX_STATUS   = 7'h20;
  localparam logic [6:0] IDX_DIOMAP   = 7'h25;
  localparam logic [6:0] IDX_TUNE_A   = 7'h5A;
  localparam logic [6:0] IDX_TUNE_B   = 7'h5C;

  // ==========================================================
  // Values after reset
  localparam logic [7:0]  RST_CTRL   = 8'h01;
  localparam logic [15:0] RST_BR     = 16'h1A0B;
  localparam logic [13:0] RST_FDEV   = 14'h0052;
  localparam logic [7:0]  RST_LEVEL  = 8'h9F;
  localparam logic [7:0]  RST_RAMP   = 8'h00;
  localparam logic [7:0]  RST_OCP    = 8'h1A;
  localparam logic [7:0]  RST_TUNE_A = 8'h55;
  localparam logic [7:0]  RST_TUNE_B = 8'h70;
  localparam logic [7:0]  RST_DIOMAP = 8'h00;

  // High-power tuning values
  localparam logic [7:0]  HP_OCP    = 8'h0F;
  localparam logic [7:0]  HP_TUNE_A = 8'h5D;
  localparam logic [7:0]  HP_TUNE_B = 8'h7C;

  // ==========================================================
  // Field positions
  localparam int CTRL_SEQ  = 0;            // Built-in sequencer enable
  localparam int CTRL_TX   = 1;            // Transmit requested
  localparam int CTRL_OOK  = 2;            // 1 = OOK, 0 = FSK
  localparam int CTRL_CONT = 3;            // 1 = continuous, 0 = packet
  localparam int CTRL_GO   = 4;            // Manual launch when sequencer off
  localparam int LVL_MAIN  = 7;
  localparam int LVL_A     = 6;
  localparam int LVL_B     = 5;
  localparam int ST_LOCK   = 0;
  localparam int ST_TX     = 1;
  localparam int ST_HP     = 2;
  localparam int ST_RSVD   = 3;

  // ==========================================================
  // Shaping select codes and Gaussian step shifts
  localparam logic [1:0] SHAPE_NONE = 2'h0;
  localparam logic [1:0] SHAPE_BT10 = 2'h1;
  localparam logic [1:0] SHAPE_BT05 = 2'h2;
  localparam logic [1:0] SHAPE_BT03 = 2'h3;
  localparam logic [3:0] SHIFT_BT10 = 4'h2;
  localparam logic [3:0] SHIFT_BT05 = 4'h3;
  localparam logic [3:0] SHIFT_BT03 = 4'h4;

  // Power offsets in dBm: -18, -14, -11
  localparam logic signed [5:0] PWR_OFS_LOW = 6'sh2E;
  localparam logic signed [5:0] PWR_OFS_MID = 6'sh32;
  localparam logic signed [5:0] PWR_OFS_HP  = 6'sh35;

  localparam logic [15:0] BR_MIN   = 16'h0002;
  localparam logic [7:0]  BIAS_MAX = 8'hFF;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SYNTH, SEQ_TX} rtm_seq_e;

endpackage

// file: pkg/rtm_bit_if.sv
// Purpose: Bit timing link between the control core and the bit clock.
// Assumes: One clock domain, clk_sys.
// Notes:   Ticks are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none

interface rtm_bit_if;
  logic        en;
  logic [15:0] divider;
  logic        bit_tick;
  logic        mid_tick;
  logic        strobe;

  modport ctl (output en, output divider, input bit_tick, input mid_tick, input strobe);
  modport gen (input en, input divider, output bit_tick, output mid_tick, output strobe);
endinterface

`default_nettype wire

// file: src/rtm_bitclk.sv
// Purpose: Bit period counter and bit strobe generator.
// Assumes: divider is at least two; en drops outside transmission.
// Notes:   Strobe rises at each bit start and falls at mid-bit.
`timescale 1ns/1ps
`default_nettype none

module rtm_bitclk
  import rtm_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic ce,
  rtm_bit_if.gen    bus
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
    logic        mid;
    logic        strobe;
  } rtm_bclk_s;

  localparam rtm_bclk_s RST_BCLK = '{cnt: 16'h0000, tick: 1'b0, mid: 1'b0, strobe: 1'b0};

  rtm_bclk_s st;
  rtm_bclk_s next_st;

  // ==========================================================
  // Divider count; a bit starts whenever the count wraps to zero
  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    next_st.mid  = 1'b0;
    if (!bus.en) begin
      next_st.cnt    = 16'h0000;
      next_st.strobe = 1'b0;
    end else begin
      if (st.cnt >= bus.divider - 16'h0001) begin
        next_st.cnt = 16'h0000;
      end else begin
        next_st.cnt = st.cnt + 16'h0001;
      end
      next_st.tick   = (next_st.cnt == 16'h0000);
      next_st.mid    = (next_st.cnt == {1'b0, bus.divider[15:1]});
      next_st.strobe = (next_st.cnt < {1'b0, bus.divider[15:1]});
    end
  end

  // Frozen while ce is low
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= RST_BCLK;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign bus.bit_tick = st.tick;
  assign bus.mid_tick = st.mid;
  assign bus.strobe   = st.strobe;

endmodule

`default_nettype wire

// file: src/rtm_top.sv
// Purpose: Transmit modulation control with AHB-Lite register slave.
// Assumes: clk_sys is the crystal reference; pins are asynchronous.
// Notes:   Single zero-wait slave, always OKAY.
//
// What this block does
// - With sequencer on, start transmit by itself once synthesizer locks.
// - Drive lock indication high in range; route it to chosen GPIO outputs.
// - Lock may drop during wide-deviation FSK; transmission is not aborted.
// - Continuous unshaped mode passes data pin level straight to modulator.
// - Shaped continuous mode emits bit strobe whenever next bit is needed.
// - Bit period equals crystal cycles given by 16-bit divider, high and low byte.
// - Deviation equals synthesizer step times 14-bit deviation word.
// - OOK keys amplifier on for one, off for zero.
// - FSK shaping select picks Gaussian BT 0.3, 0.5 or 1.
// - OOK with shaping ramps amplifier bias up and down smoothly.
// - Main amp alone routes to RF pin at -18 dBm plus level; others reserved.
// - Boost stage A alone drives boost pin at -18 dBm plus level.
// - Both boost stages, normal settings, drive boost pin at -14 dBm plus level.
// - Both boost stages, high-power settings, drive at -11 dBm plus level.
// - Synthesizer step is crystal frequency over two to the 19.
`timescale 1ns/1ps
`default_nettype none

module rtm_top
  import rtm_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Pins and analog
  input  wire logic        synth_lock_raw,
  input  wire logic        serial_tx_data_pin,
  output logic             bit_strobe_pin,
  output logic      [1:0]  gpio_out,
  output logic             synth_enable,
  output logic             tx_active,
  output logic             mod_bit,
  output logic signed [15:0] fdev_offset,
  output logic             main_amp_on,
  output logic             boost_stage_a_on,
  output logic             boost_stage_b_on,
  output logic             rf_io_drive,
  output logic             boost_pin_drive,
  output logic      [7:0]  pa_bias,
  output logic signed [5:0] pa_dbm,
  output logic      [7:0]  ocp_setting,
  output logic      [7:0]  hp_tune_a_out,
  output logic      [7:0]  hp_tune_b_out
);

  // ==========================================================
  // State
  typedef struct packed {
    logic        lock_m;
    logic        lock_q;
    logic        data_m;
    logic        data_q;
    logic        wr_pend;
    logic [6:0]  wr_idx;
    logic [31:0] rdata;
    logic        rdy;
    logic [7:0]  ctrl;
    logic [15:0] bit_period_register;
    logic [13:0] fdev;
    logic [7:0]  amp_level_register;
    logic [7:0]  shaping_register;
    logic [7:0]  overcurrent_limit_ctrl;
    logic [7:0]  high_power_tune_a;
    logic [7:0]  high_power_tune_b;
    logic [7:0]  dio_map;
    rtm_seq_e    seq;
    logic        held_bit;
    logic        tx_bit;
    logic signed [15:0] offs;
    logic [7:0]  bias;
    logic [1:0]  gpio;
    logic        strobe_o;
    logic        amp_main;
    logic        amp_a;
    logic        amp_b;
    logic        rf_drv;
    logic        boost_drv;
    logic signed [5:0] dbm;
    logic        syn_en;
    logic        tx_on;
  } rtm_state_s;

  localparam rtm_state_s RST_STATE = '{
    lock_m: 1'b0, lock_q: 1'b0, data_m: 1'b0, data_q: 1'b0,
    wr_pend: 1'b0, wr_idx: 7'h00, rdata: 32'h0000_0000, rdy: 1'b1,
    ctrl: RST_CTRL, bit_period_register: RST_BR, fdev: RST_FDEV,
    amp_level_register: RST_LEVEL, shaping_register: RST_RAMP,
    overcurrent_limit_ctrl: RST_OCP, high_power_tune_a: RST_TUNE_A,
    high_power_tune_b: RST_TUNE_B, dio_map: RST_DIOMAP,
    seq: SEQ_IDLE, held_bit: 1'b0, tx_bit: 1'b0, offs: 16'sh0000,
    bias: 8'h00, gpio: 2'h0, strobe_o: 1'b0, amp_main: 1'b0, amp_a: 1'b0,
    amp_b: 1'b0, rf_drv: 1'b0, boost_drv: 1'b0, dbm: 6'sh00, syn_en: 1'b0, tx_on: 1'b0
  };

  rtm_state_s st;
  rtm_state_s next_st;
  rtm_bit_if  bit_link ();

  // ==========================================================
  // Register read mux; unmapped indices read zero
  function automatic logic [31:0] read_reg(input rtm_state_s s, input logic [6:0] idx,
                                           input logic hp);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      IDX_CTRL:     v = s.ctrl;
      IDX_BR_MSB:   v = s.bit_period_register[15:8];
      IDX_BR_LSB:   v = s.bit_period_register[7:0];
      IDX_FDEV_MSB: v = {2'h0, s.fdev[13:8]};
      IDX_FDEV_LSB: v = s.fdev[7:0];
      IDX_LEVEL:    v = s.amp_level_register;
      IDX_RAMP:     v = s.shaping_register;
      IDX_OCP:      v = s.overcurrent_limit_ctrl;
      IDX_STATUS:   v = {4'h0, !(s.amp_main || s.amp_a) && (s.seq == SEQ_TX),
                         hp, s.seq == SEQ_TX, s.lock_q};
      IDX_DIOMAP:   v = s.dio_map;
      IDX_TUNE_A:   v = s.high_power_tune_a;
      IDX_TUNE_B:   v = s.high_power_tune_b;
      default:      v = 8'h00;
    endcase
    return {24'h000000, v};
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic        async_mode;
    logic        ook;
    logic        key;
    logic        shaped;
    logic        hp;
    logic        combo_main;
    logic        combo_a;
    logic        combo_ab;
    logic [3:0]  shift;
    logic signed [15:0] tgt;
    logic signed [15:0] step;
    logic signed [15:0] diff;
    logic [7:0]  bias_tgt;
    logic signed [5:0] ofs;

    next_st    = st;
    async_mode = 1'b0;
    ook        = 1'b0;
    key        = 1'b0;
    shaped     = 1'b0;
    hp         = 1'b0;
    combo_main = 1'b0;
    combo_a    = 1'b0;
    combo_ab   = 1'b0;
    shift      = SHIFT_BT10;
    tgt        = 16'sh0000;
    step       = 16'sh0000;
    diff       = 16'sh0000;
    bias_tgt   = 8'h00;
    ofs        = PWR_OFS_LOW;

    // Two-stage synchronisers for the asynchronous pins
    next_st.lock_m = synth_lock_raw;
    next_st.lock_q = st.lock_m;
    next_st.data_m = serial_tx_data_pin;
    next_st.data_q = st.data_m;

    // Data phase of a write registered in the previous cycle
    next_st.wr_pend = 1'b0;
    if (st.wr_pend) begin
      unique case (st.wr_idx)
        IDX_CTRL:     next_st.ctrl = hwdata[7:0];
        IDX_BR_MSB:   next_st.bit_period_register[15:8] = hwdata[7:0];
        IDX_BR_LSB:   next_st.bit_period_register[7:0] = hwdata[7:0];
        IDX_FDEV_MSB: next_st.fdev[13:8] = hwdata[5:0];
        IDX_FDEV_LSB: next_st.fdev[7:0] = hwdata[7:0];
        IDX_LEVEL:    next_st.amp_level_register = hwdata[7:0];
        IDX_RAMP:     next_st.shaping_register = hwdata[7:0];
        IDX_OCP:      next_st.overcurrent_limit_ctrl = hwdata[7:0];
        IDX_DIOMAP:   next_st.dio_map = hwdata[7:0];
        IDX_TUNE_A:   next_st.high_power_tune_a = hwdata[7:0];
        IDX_TUNE_B:   next_st.high_power_tune_b = hwdata[7:0];
        default:      next_st.wr_pend = 1'b0;                             // Ignored
      endcase
    end

    // Mode decode from the freshest register values
    ook        = next_st.ctrl[CTRL_OOK];
    shaped     = (next_st.shaping_register[1:0] != SHAPE_NONE);
    async_mode = next_st.ctrl[CTRL_CONT] && !shaped;
    hp         = (next_st.high_power_tune_a == HP_TUNE_A) &&
                 (next_st.high_power_tune_b == HP_TUNE_B);

    // Address phase; reads see a write finishing in the same cycle
    if (hsel && hready && htrans[1]) begin
      next_st.wr_pend = hwrite;
      next_st.wr_idx  = haddr[8:2];
      if (!hwrite) begin
        next_st.rdata = read_reg(next_st, haddr[8:2], hp);
      end
    end
    next_st.rdy = 1'b1;

    // Start-up sequencing
    unique case (st.seq)
      SEQ_IDLE: begin
        if (st.ctrl[CTRL_TX]) begin
          next_st.seq = SEQ_SYNTH;
        end
      end
      SEQ_SYNTH: begin
        if (!st.ctrl[CTRL_TX]) begin
          next_st.seq = SEQ_IDLE;
        end else if (st.ctrl[CTRL_SEQ] ? st.lock_q : st.ctrl[CTRL_GO]) begin
          next_st.seq = SEQ_TX;
        end
      end
      SEQ_TX: begin
        // Loss of lock while modulating is tolerated, only a stop ends it
        if (!st.ctrl[CTRL_TX]) begin
          next_st.seq = SEQ_IDLE;
        end
      end
    endcase

    // Sequencer status flops, so the pins carry no decode glitches
    next_st.syn_en = (next_st.seq != SEQ_IDLE);
    next_st.tx_on  = (next_st.seq == SEQ_TX);

    // Lock event onto selected GPIO outputs
    next_st.gpio = st.dio_map[1:0] & {2{st.lock_q}};

    // Transmit bit source
    if (st.seq != SEQ_TX) begin
      next_st.tx_bit   = 1'b0;
      next_st.held_bit = 1'b0;
    end else if (async_mode) begin
      next_st.tx_bit = st.data_q;
    end else begin
      // Sampled mid-bit, applied at the next bit start for a whole period
      if (bit_link.mid_tick) begin
        next_st.held_bit = st.data_q;
      end
      if (bit_link.bit_tick) begin
        next_st.tx_bit = st.held_bit;
      end
    end
    next_st.strobe_o = bit_link.strobe && (st.seq == SEQ_TX) &&
                       st.ctrl[CTRL_CONT];

    // FSK deviation in fractional divider steps of crystal / 2**19
    unique case (st.shaping_register[1:0])
      SHAPE_BT05: shift = SHIFT_BT05;
      SHAPE_BT03: shift = SHIFT_BT03;
      default:    shift = SHIFT_BT10;
    endcase
    tgt  = st.tx_bit ? $signed({2'b00, st.fdev}) : -$signed({2'b00, st.fdev});
    step = $signed({2'b00, st.fdev >> shift});
    if (step == 16'sh0000) begin
      step = 16'sh0001;
    end
    diff = tgt - st.offs;
    if ((st.seq != SEQ_TX) || ook) begin
      next_st.offs = 16'sh0000;
    end else if (!shaped || (diff <= step && diff >= -step)) begin
      next_st.offs = tgt;
    end else if (diff > 16'sh0000) begin
      next_st.offs = st.offs + step;
    end else begin
      next_st.offs = st.offs - step;
    end

    // Amplifier bias: OOK keys it, OOK shaping ramps it one step per cycle
    key      = (st.seq == SEQ_TX) && (!ook || st.tx_bit);
    bias_tgt = key ? BIAS_MAX : 8'h00;
    if (ook && shaped && (st.bias < bias_tgt)) begin
      next_st.bias = st.bias + 8'h01;
    end else if (ook && shaped && (st.bias > bias_tgt)) begin
      next_st.bias = st.bias - 8'h01;
    end else begin
      next_st.bias = bias_tgt;
    end

    // Amplifier path selection; unlisted combinations drive nothing
    combo_main = (st.amp_level_register[7:5] == 3'b100);
    combo_a    = (st.amp_level_register[7:5] == 3'b010);
    combo_ab   = (st.amp_level_register[7:5] == 3'b011);
    if (combo_ab) begin
      ofs = hp ? PWR_OFS_HP : PWR_OFS_MID;
    end else begin
      ofs = PWR_OFS_LOW;
    end
    next_st.dbm       = ofs + $signed({1'b0, st.amp_level_register[4:0]});
    next_st.amp_main  = combo_main && (next_st.bias != 8'h00);
    next_st.amp_a     = (combo_a || combo_ab) && (next_st.bias != 8'h00);
    next_st.amp_b     = combo_ab && (next_st.bias != 8'h00);
    next_st.rf_drv    = next_st.amp_main;
    next_st.boost_drv = next_st.amp_a;
  end

  // ==========================================================
  // Bit clock
  assign bit_link.en      = (st.seq == SEQ_TX) && !(st.ctrl[CTRL_CONT] &&
                            (st.shaping_register[1:0] == SHAPE_NONE));
  assign bit_link.divider = (st.bit_period_register < BR_MIN) ? BR_MIN
                            : st.bit_period_register;

  rtm_bitclk u_bitclk (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .ce      (ce),
    .bus     (bit_link.gen)
  );

  // Single state register, frozen while ce is low
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= RST_STATE;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs straight from state flops; hresp is tied low
  assign hrdata           = st.rdata;
  assign hreadyout        = st.rdy;
  assign hresp            = 1'b0;
  assign bit_strobe_pin   = st.strobe_o;
  assign gpio_out         = st.gpio;
  assign synth_enable     = st.syn_en;
  assign tx_active        = st.tx_on;
  assign mod_bit          = st.tx_bit;
  assign fdev_offset      = st.offs;
  assign main_amp_on      = st.amp_main;
  assign boost_stage_a_on = st.amp_a;
  assign boost_stage_b_on = st.amp_b;
  assign rf_io_drive      = st.rf_drv;
  assign boost_pin_drive  = st.boost_drv;
  assign pa_bias          = st.bias;
  assign pa_dbm           = st.dbm;
  assign ocp_setting      = st.overcurrent_limit_ctrl;
  assign hp_tune_a_out    = st.high_power_tune_a;
  assign hp_tune_b_out    = st.high_power_tune_b;

endmodule

`default_nettype wire

// file: test/rtm_top_asserts.sv
// Purpose: Port-level assertions for rtm_top.
// Assumes: Sees only top ports; single clock domain.
// Notes:   Bound from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module rtm_top_asserts
  import rtm_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              sys_rst,
  input wire logic              synth_lock_raw,
  input wire logic        [1:0] gpio_out,
  input wire logic              synth_enable,
  input wire logic              tx_active,
  input wire logic              bit_strobe_pin,
  input wire logic              rf_io_drive,
  input wire logic              main_amp_on,
  input wire logic              boost_stage_a_on,
  input wire logic              boost_stage_b_on,
  input wire logic              boost_pin_drive,
  input wire logic signed [5:0] pa_dbm,
  input wire logic        [7:0] hp_tune_a_out,
  input wire logic        [7:0] hp_tune_b_out
);
  // ==========================================================
  // Defaults and helpers
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic hp;
  assign hp = (hp_tune_a_out == HP_TUNE_A) && (hp_tune_b_out == HP_TUNE_B);
  // ==========================================================
  // Properties; lock path allows two to four cycles of sync delay
  property p_tx_synth; tx_active |-> synth_enable; endproperty
  a_tx_synth: assert property (p_tx_synth) else $error("tx without synth");
  property p_tx_rise; $rose(tx_active) |-> $past(synth_enable); endproperty
  a_tx_rise: assert property (p_tx_rise) else $error("tx skipped synth");
  property p_gpio; |gpio_out |-> $past(synth_lock_raw, 2) || $past(synth_lock_raw, 3)
    || $past(synth_lock_raw, 4); endproperty
  a_gpio: assert property (p_gpio) else $error("gpio lock without lock");
  property p_unlock; $fell(synth_lock_raw) && tx_active |=> tx_active [*4]; endproperty
  a_unlock: assert property (p_unlock) else $error("tx dropped on unlock");
  property p_strobe; bit_strobe_pin |-> tx_active; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe outside tx");
  property p_rf_io_pin; rf_io_drive |-> main_amp_on && !boost_stage_a_on && !boost_stage_b_on;
  endproperty
  a_rf_io_pin: assert property (p_rf_io_pin) else $error("rf pin mode mix");
  property p_boostb; boost_stage_b_on |-> boost_stage_a_on && boost_pin_drive; endproperty
  a_boostb: assert property (p_boostb) else $error("stage b alone");
  property p_hp; (boost_stage_b_on && hp) [*3] |-> pa_dbm >= PWR_OFS_HP; endproperty
  a_hp: assert property (p_hp) else $error("high power offset low");
endmodule
`default_nettype wire

// file: test/rtm_host_model.sv
// Purpose: Host model driving the transmit data pin.
// Assumes: Strobe is synchronous to clk_sys.
// Notes:   Manual mode gives the bench the pin level.
`timescale 1ns/1ps
`default_nettype none
module rtm_host_model (
  input  wire logic clk_sys,
  input  wire logic bit_strobe_pin,
  input  wire logic manual,
  input  wire logic manual_bit,
  output logic      serial_tx_data_pin
);
  logic [7:0] pat = 8'hB4;
  logic       strobe_q = 1'b0;
  // ==========================================================
  // Next bit just after each strobe rise, held the whole bit
  always @(posedge clk_sys) begin
    strobe_q <= bit_strobe_pin;
    if (manual) begin
      serial_tx_data_pin <= manual_bit;
    end else if (bit_strobe_pin && !strobe_q) begin
      serial_tx_data_pin <= pat[0];
      pat <= {pat[0], pat[7:1]};
    end
  end
endmodule
`default_nettype wire

// file: test/rtm_top_tb.sv
// Purpose: Self-checking bench for rtm_top.
// Assumes: hready loops back from hreadyout.
// Notes:   Lock input and data pin are driven here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("Error at %0t: got %h exp %h", $time, a, e); end end
module rtm_top_tb
  import rtm_pkg::*;
;
  logic               clk_sys = 0, sys_rst = 1, ce = 1, hsel = 0, hwrite = 0, hready;
  logic               synth_lock_raw = 0, manual = 1, manual_bit = 0, serial_tx_data_pin;
  logic        [1:0]  htrans = 0, gpio_out;
  logic        [2:0]  hsize = 3'h2;
  logic        [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic               hreadyout, hresp, bit_strobe_pin, synth_enable, tx_active, mod_bit;
  logic               main_amp_on, boost_stage_a_on, boost_stage_b_on;
  logic               rf_io_drive, boost_pin_drive;
  logic signed [15:0] fdev_offset;
  logic signed [5:0]  pa_dbm;
  logic        [7:0]  pa_bias, ocp_setting, hp_tune_a_out, hp_tune_b_out;
  int                 fail_count = 0, checks = 0, cyc = 0;
  // ==========================================================
  // Clock, bus loopback, instances
  always #5 clk_sys = ~clk_sys;
  assign hready = hreadyout;
  rtm_top rtm_top_inst (.clk_sys, .sys_rst, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .synth_lock_raw, .serial_tx_data_pin,
    .bit_strobe_pin, .gpio_out, .synth_enable, .tx_active, .mod_bit, .fdev_offset,
    .main_amp_on, .boost_stage_a_on, .boost_stage_b_on, .rf_io_drive, .boost_pin_drive,
    .pa_bias, .pa_dbm, .ocp_setting, .hp_tune_a_out, .hp_tune_b_out);
  rtm_host_model rtm_host_model_inst (.clk_sys, .bit_strobe_pin, .manual, .manual_bit,
    .serial_tx_data_pin);
  // ==========================================================
  // Bus and timing helpers; ahb waits on hreadyout with no bound of its own, only the hang limit
  task automatic ahb(input logic wr, input logic [6:0] idx, input logic [7:0] wd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {23'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    do begin @(posedge clk_sys); end while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    do begin @(posedge clk_sys); end while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    logic [6:0] ix [4] = '{IDX_OCP, IDX_TUNE_A, IDX_TUNE_B, 7'h7F};
    logic [7:0] ev [4] = '{RST_OCP, RST_TUNE_A, RST_TUNE_B, 8'h00};
    for (int i = 0; i < 4; i++) begin
      ahb(1'b0, ix[i], 8'h00);
      `CHK(rd, {24'h0, ev[i]})
    end
    $display("t_regs done");
  endtask
  task automatic t_async;
    ahb(1'b1, IDX_DIOMAP, 8'h03);
    ahb(1'b1, IDX_FDEV_LSB, 8'h40);
    ahb(1'b1, IDX_CTRL, 8'h0B);
    settle(8);
    `CHK(tx_active, 1'b0)
    `CHK(synth_enable, 1'b1)
    @(posedge clk_sys) synth_lock_raw <= 1'b1;
    settle(8);
    `CHK(tx_active, 1'b1)
    `CHK(gpio_out, 2'b11)
    for (int b = 1; b >= 0; b--) begin
      @(posedge clk_sys) manual_bit <= b[0];
      settle(6);
      `CHK(mod_bit, b[0])
      `CHK(fdev_offset, b[0] ? 16'sh0040 : 16'shFFC0)
    end
    @(posedge clk_sys) synth_lock_raw <= 1'b0;
    settle(8);
    `CHK(tx_active, 1'b1)
    `CHK(gpio_out, 2'b00)
    @(posedge clk_sys) synth_lock_raw <= 1'b1;
    $display("t_async done");
  endtask
  task automatic t_power;
    logic [7:0]        lv [4] = '{8'h85, 8'h45, 8'h65, 8'hE5};
    logic [2:0]        ep [4] = '{3'h4, 3'h2, 3'h3, 3'h0};
    logic signed [5:0] ed [3] = '{PWR_OFS_LOW, PWR_OFS_LOW, PWR_OFS_MID};
    for (int i = 0; i < 4; i++) begin
      ahb(1'b1, IDX_LEVEL, lv[i]);
      settle(4);
      `CHK({rf_io_drive, boost_pin_drive, boost_stage_b_on}, ep[i])
      if (i < 3) `CHK(pa_dbm, ed[i] + 6'sd5)
    end
    ahb(1'b1, IDX_OCP, HP_OCP);
    ahb(1'b1, IDX_TUNE_A, HP_TUNE_A);
    ahb(1'b1, IDX_TUNE_B, HP_TUNE_B);
    ahb(1'b1, IDX_LEVEL, 8'h65);
    settle(4);
    `CHK(pa_dbm, PWR_OFS_HP + 6'sd5)
    `CHK(ocp_setting, HP_OCP)
    `CHK(hp_tune_b_out, HP_TUNE_B)
    ahb(1'b1, IDX_TUNE_A, RST_TUNE_A);
    ahb(1'b1, IDX_TUNE_B, RST_TUNE_B);
    ahb(1'b1, IDX_LEVEL, 8'h85);
    ahb(1'b1, IDX_CTRL, 8'h0F);
    for (int b = 1; b >= 0; b--) begin
      @(posedge clk_sys) manual_bit <= b[0];
      settle(6);
      `CHK(main_amp_on, b[0])
    end
    $display("t_power done");
  endtask
  task automatic t_shaped;
    int         n;
    logic       p, e, pe;
    logic [7:0] b0;
    ahb(1'b1, IDX_BR_MSB, 8'h00);
    ahb(1'b1, IDX_BR_LSB, 8'h80);
    @(posedge clk_sys) manual <= 1'b0;
    for (int c = 1; c < 4; c++) begin
      ahb(1'b1, IDX_CTRL, 8'h00);
      ahb(1'b1, IDX_RAMP, 8'(c));
      ahb(1'b1, IDX_CTRL, 8'h0B);
      for (int i = 0; i < 5; i++) begin
        n = 0;
        do begin p = bit_strobe_pin; settle(1); n++; end
          while (!(bit_strobe_pin === 1'b1 && p === 1'b0) && n < 300);
        e = serial_tx_data_pin;
        // Two cycles of the previous pass were spent after its rise
        if (i > 1) `CHK(n + 2, 32'h80)
        settle(2);
        if (i > 1) `CHK(mod_bit, e)
        // Two slew steps in, the offset is still short of its target
        if (i > 1 && e != pe) `CHK(fdev_offset !== (e ? 16'sh0040 : 16'shFFC0), 1'b1)
        pe = e;
      end
    end
    // OOK with shaping: bias walks down one step per cycle after a falling bit
    ahb(1'b1, IDX_CTRL, 8'h0F);
    n = 0;
    do begin p = mod_bit; settle(1); n++; end
      while (!(p === 1'b1 && mod_bit === 1'b0) && n < 600);
    `CHK(n < 600, 1'b1)
    settle(1);
    b0 = pa_bias;
    settle(1);
    `CHK(pa_bias, b0 - 8'h01)
    $display("t_shaped done");
  endtask
  // ==========================================================
  // Verdict, hang limit and main sequence
  task print_verdict;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict;
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs;
    t_async;
    t_power;
    t_shaped;
    print_verdict;
  end
endmodule
bind rtm_top rtm_top_asserts rtm_top_asserts_inst (.clk_sys, .sys_rst, .synth_lock_raw,
  .gpio_out, .synth_enable, .tx_active, .bit_strobe_pin, .rf_io_drive, .main_amp_on,
  .boost_stage_a_on, .boost_stage_b_on, .boost_pin_drive, .pa_dbm, .hp_tune_a_out,
  .hp_tune_b_out);
`default_nettype wire
